// >>> common/itss_params.svh
// Register offsets, field positions and reset values of the idle-timer SMI status block.
// Included by the package and the design; definitions only.
`ifndef ITSS_PARAMS_SVH
`define ITSS_PARAMS_SVH
// Indices are word indices, not byte addresses: byte address is four times the index
`define ITSS_IDX_IDLE_MIRROR 8'h85
`define ITSS_IDX_IDLE_FLAGS 8'hF5
`define ITSS_IDX_TRAP_FLAGS 8'hF6
`define ITSS_IDX_IDLE_EN 8'h81
`define ITSS_IDX_TRAP_EN 8'h82
`define ITSS_IDX_TRAP_MIRROR 8'h86
`define ITSS_IDX_TOP_STATUS 8'hE0
`define ITSS_IDX_IRQ_MASK 8'hE1
`define ITSS_BIT_VIDEO_TRAP 7
`define ITSS_BIT_TOP_SMI 0
`define ITSS_RST_FLAGS 8'h00
`define ITSS_RST_EN 8'h00
`define ITSS_RST_MASK 8'h01
`endif

// >>> common/itss_pkg.sv
// Types of the idle-timer SMI status block.
// Assumes itss_params.svh is on the include path.
package itss_pkg;
  `include "itss_params.svh"
  typedef struct packed {
    logic [7:0] idle_expire;
    logic video_trap;
  } itss_evt_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } itss_rsp_t;
endpackage

// >>> logic/itss_core.sv
// Second-level SMI status for the idle timers and the video access trap.
// Assumes APB master on pclk; event pulses come from logic on the same clock.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "itss_params.svh"
module itss_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire itss_pkg::itss_evt_t evt,
  output itss_pkg::itss_rsp_t rsp,
  output logic smi_irq
);
  import itss_pkg::*;

  logic [7:0] idle_flags_q;
  logic [7:0] idle_flags_d;
  logic trap_flag_q;
  logic trap_flag_d;
  logic [7:0] idle_en_q;
  logic [7:0] trap_en_q;
  logic irq_mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic access;
  logic rd_access;
  logic wr_access;
  logic [7:0] idx;
  logic idle_clr;
  logic trap_clr;
  logic [7:0] idle_set;
  logic trap_set;
  logic top_smi;
  logic mapped;
  logic rd_setup;

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    byte_merge = st[0] ? wd[7:0] : old;
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [7:0] i);
    addr_is = (a == {2'h0, i, 2'h0});
  endfunction

  // Single-cycle answer: pready is high in every access phase
  assign access = psel && penable && clk_en;
  assign rd_access = access && !pwrite;
  assign wr_access = access && pwrite;
  assign rd_setup = psel && !penable && clk_en && !pwrite;
  assign idx = paddr[9:2];
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  ((idx == `ITSS_IDX_IDLE_MIRROR) || (idx == `ITSS_IDX_IDLE_FLAGS) ||
                   (idx == `ITSS_IDX_TRAP_FLAGS) || (idx == `ITSS_IDX_IDLE_EN) ||
                   (idx == `ITSS_IDX_TRAP_EN) || (idx == `ITSS_IDX_TRAP_MIRROR) ||
                   (idx == `ITSS_IDX_TOP_STATUS) || (idx == `ITSS_IDX_IRQ_MASK));

  assign idle_clr = rd_access && addr_is(paddr, `ITSS_IDX_IDLE_FLAGS);
  assign trap_clr = rd_access && addr_is(paddr, `ITSS_IDX_TRAP_FLAGS);

  assign idle_set = evt.idle_expire & idle_en_q;
  assign trap_set = evt.video_trap && trap_en_q[`ITSS_BIT_VIDEO_TRAP];

  always_comb begin
    // Only bits already returned are cleared, so a setup-cycle event is kept
    idle_flags_d = (idle_clr ? (idle_flags_q & ~prdata_q[7:0]) : idle_flags_q) | idle_set;
    trap_flag_d = (trap_clr ? (trap_flag_q && !prdata_q[7]) : trap_flag_q) || trap_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_flags_q <= `ITSS_RST_FLAGS;
      trap_flag_q <= 1'b0;
    end else if (clk_en) begin
      idle_flags_q <= idle_flags_d;
      trap_flag_q <= trap_flag_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_en_q <= `ITSS_RST_EN;
      trap_en_q <= `ITSS_RST_EN;
      irq_mask_q <= 1'b1;
    end else if (wr_access) begin
      if (addr_is(paddr, `ITSS_IDX_IDLE_EN)) begin
        idle_en_q <= byte_merge(idle_en_q, pwdata, pstrb);
      end
      if (addr_is(paddr, `ITSS_IDX_TRAP_EN)) begin
        trap_en_q <= byte_merge(trap_en_q, pwdata, pstrb);
      end
      if (addr_is(paddr, `ITSS_IDX_IRQ_MASK) && pstrb[0]) begin
        irq_mask_q <= pwdata[`ITSS_BIT_TOP_SMI];
      end
    end
  end

  assign top_smi = (|idle_flags_q) || trap_flag_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable && clk_en) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= !mapped;
      if (!pwrite) begin
        unique case (idx)
          `ITSS_IDX_IDLE_MIRROR, `ITSS_IDX_IDLE_FLAGS: prdata_q <= {24'h0, idle_flags_q};
          `ITSS_IDX_TRAP_MIRROR, `ITSS_IDX_TRAP_FLAGS: prdata_q <= {24'h0, trap_flag_q, 7'h00};
          `ITSS_IDX_IDLE_EN: prdata_q <= {24'h0, idle_en_q};
          `ITSS_IDX_TRAP_EN: prdata_q <= {24'h0, trap_en_q};
          `ITSS_IDX_TOP_STATUS: prdata_q <= {31'h0, top_smi};
          `ITSS_IDX_IRQ_MASK: prdata_q <= {31'h0, irq_mask_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Read data is captured in setup, so a flag set during access is kept, not lost
  assign rsp.prdata = prdata_q;
  assign rsp.pready = 1'b1;
  assign rsp.pslverr = pslverr_q;

  assign smi_irq = top_smi && irq_mask_q;

  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    idle_clr && !(|idle_set) |=> (idle_flags_q & $past(prdata_q[7:0])) == 8'h00)
    else $error("Idle flags not cleared by read");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    idle_clr && idle_set[0] |=> idle_flags_q[0])
    else $error("Event lost in clearing read");

  AST_IDLE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[7] && idle_en_q[7] |=> idle_flags_q[7])
    else $error("Video idle flag not set");

  AST_IDLE_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[0] && !(evt.idle_expire[0] && idle_en_q[0])
    |=> !idle_flags_q[0])
    else $error("Idle flag set without enabled expiry");

  AST_MIRROR_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    rd_access && addr_is(paddr, `ITSS_IDX_IDLE_MIRROR) && !(|idle_set)
    |=> idle_flags_q == $past(idle_flags_q))
    else $error("Mirror read changed flags");

  AST_TRAP_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && trap_set |=> trap_flag_q)
    else $error("Trap flag not set");

  AST_TRAP_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    trap_clr && prdata_q[7] && !trap_set |=> !trap_flag_q)
    else $error("Trap flag not cleared by read");

  AST_SUMMARY: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && (idx == `ITSS_IDX_TOP_STATUS)
    |=> prdata_q[0] == $past((idle_flags_q != 8'h00) || trap_flag_q))
    else $error("Summary bit disagrees with flags");

  AST_IRQ_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    idle_clr && (idle_flags_q == prdata_q[7:0]) && !trap_flag_q && !(|idle_set) && !trap_set
    |=> !smi_irq)
    else $error("Interrupt held after clear");

  AST_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && addr_is(paddr, `ITSS_IDX_IDLE_FLAGS) && !(|idle_set)
    |=> idle_flags_q == $past(idle_flags_q))
    else $error("Write altered idle flags");

  AST_RST_CLEAR: assert property (@(posedge pclk)
    !presetn |-> (idle_flags_q == 8'h00) && !trap_flag_q && !smi_irq)
    else $error("Flags not zero in reset");

  AST_SET_B6: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[6] && idle_en_q[6] |=> idle_flags_q[6])
    else $error("Flag 6 not set");

  AST_SET_B5: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[5] && idle_en_q[5] |=> idle_flags_q[5])
    else $error("Flag 5 not set");

  AST_SET_B4: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[4] && idle_en_q[4] |=> idle_flags_q[4])
    else $error("Flag 4 not set");

  AST_SET_B3: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[3] && idle_en_q[3] |=> idle_flags_q[3])
    else $error("Flag 3 not set");

  AST_SET_B2: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[2] && idle_en_q[2] |=> idle_flags_q[2])
    else $error("Flag 2 not set");

  AST_SET_B1: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[1] && idle_en_q[1] |=> idle_flags_q[1])
    else $error("Flag 1 not set");

  AST_SET_B0: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && evt.idle_expire[0] && idle_en_q[0] |=> idle_flags_q[0])
    else $error("Flag 0 not set");

  AST_GATED_B7: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[7] && !(evt.idle_expire[7] && idle_en_q[7])
    |=> !idle_flags_q[7])
    else $error("Flag 7 set without enabled expiry");

  AST_GATED_B6: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[6] && !(evt.idle_expire[6] && idle_en_q[6])
    |=> !idle_flags_q[6])
    else $error("Flag 6 set without enabled expiry");

  AST_GATED_B5: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[5] && !(evt.idle_expire[5] && idle_en_q[5])
    |=> !idle_flags_q[5])
    else $error("Flag 5 set without enabled expiry");

  AST_GATED_B4: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[4] && !(evt.idle_expire[4] && idle_en_q[4])
    |=> !idle_flags_q[4])
    else $error("Flag 4 set without enabled expiry");

  AST_GATED_B3: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[3] && !(evt.idle_expire[3] && idle_en_q[3])
    |=> !idle_flags_q[3])
    else $error("Flag 3 set without enabled expiry");

  AST_GATED_B2: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[2] && !(evt.idle_expire[2] && idle_en_q[2])
    |=> !idle_flags_q[2])
    else $error("Flag 2 set without enabled expiry");

  AST_GATED_B1: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !idle_clr && !idle_flags_q[1] && !(evt.idle_expire[1] && idle_en_q[1])
    |=> !idle_flags_q[1])
    else $error("Flag 1 set without enabled expiry");

  AST_TRAP_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !trap_clr && !trap_flag_q && !trap_set
    |=> !trap_flag_q)
    else $error("Trap flag set without enabled trap");

  // clearing read steps: setup then access
  sequence seq_flags_setup;
    rd_setup && (idx == `ITSS_IDX_IDLE_FLAGS);
  endsequence
  sequence seq_flags_clear;
    idle_clr;
  endsequence

  AST_RD_RETURNS: assert property (@(posedge pclk) disable iff (!presetn)
    seq_flags_setup ##1 seq_flags_clear |-> prdata_q[7:0] == $past(idle_flags_q))
    else $error("Clearing read returned wrong flags");

  AST_SETUP_EVT_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_flags_setup ##0 (idle_set[0] && !idle_flags_q[0])) ##1 seq_flags_clear
    |=> idle_flags_q[0])
    else $error("Setup-cycle event lost");

  AST_TRAP_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    trap_clr && trap_set |=> trap_flag_q)
    else $error("Trap event lost in clearing read");

  AST_MIRROR_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && (idx == `ITSS_IDX_IDLE_MIRROR)
    |=> prdata_q[7:0] == $past(idle_flags_q))
    else $error("Mirror read wrong data");

  AST_TRAP_RD: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && (idx == `ITSS_IDX_TRAP_FLAGS)
    |=> prdata_q[7] == $past(trap_flag_q))
    else $error("Trap read wrong data");

  AST_TRAP_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
    rd_access && addr_is(paddr, `ITSS_IDX_TRAP_MIRROR) && !trap_set
    |=> trap_flag_q == $past(trap_flag_q))
    else $error("Trap mirror read changed flag");

  AST_IRQ_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|idle_set) && irq_mask_q |=> smi_irq)
    else $error("Interrupt not raised");

  AST_IRQ_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_mask_q |-> !smi_irq)
    else $error("Interrupt high while masked");

  // Clock enable freezes flags
  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> (idle_flags_q == $past(idle_flags_q)) && (trap_flag_q == $past(trap_flag_q)))
    else $error("Flags changed while frozen");

  // Unmapped address errors
  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && clk_en && !mapped |=> pslverr_q)
    else $error("Unmapped access without error");

  AST_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && addr_is(paddr, `ITSS_IDX_IDLE_EN) && pstrb[0]
    |=> idle_en_q == $past(pwdata[7:0]))
    else $error("Idle enable write lost");
endmodule

// >>> verification/itss_tb.sv
// Self-checking bench of the idle-timer SMI status block over APB.
// Assumes itss_pkg and itss_params.svh compiled first; one pclk domain.
`timescale 1ns/100ps
`include "itss_params.svh"
module testbench;
  import itss_pkg::*;
  localparam logic [7:0] flg = `ITSS_IDX_IDLE_FLAGS;
  localparam logic [7:0] mir = `ITSS_IDX_IDLE_MIRROR;
  localparam logic [7:0] trp = `ITSS_IDX_TRAP_FLAGS;
  localparam logic [7:0] msk = `ITSS_IDX_IRQ_MASK;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  itss_evt_t evt = '0;
  itss_rsp_t rsp;
  logic smi_irq;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int num_checks = 0;
  itss_core u_itss_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .evt(evt), .rsp(rsp), .smi_irq(smi_irq));
  always #4 pclk = ~pclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Byte address is four times the index; ev is driven during the access phase only
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
      input logic [8:0] ev);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    evt <= ev;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (n == 50) check("pready", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    evt <= '0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, '0, '0);
    check(what, rd, exp);
  endtask
  task automatic pulse(input logic [7:0] idle, input logic trap);
    @(posedge pclk);
    evt <= {idle, trap};
    @(posedge pclk);
    evt <= '0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check("irq_rst", smi_irq, 0);
    rdchk(flg, 0, "flags_rst");
    rdchk(trp, 0, "trap_rst");
    rdchk(mir, 0, "mirror_rst");
    rdchk(msk, 1, "mask_rst");
    apb(1'b1, `ITSS_IDX_IDLE_EN, 32'hFF, '0);
    apb(1'b1, `ITSS_IDX_TRAP_EN, 32'h80, '0);
    for (int b = 0; b < 8; b++) begin
      pulse(8'h01 << b, 1'b0);
      rdchk(mir, 32'h1 << b, "mirror");
      rdchk(mir, 32'h1 << b, "mirror_again");
      rdchk(`ITSS_IDX_TOP_STATUS, 1, "top");
      check("irq_set", smi_irq, 1);
      rdchk(flg, 32'h1 << b, "flags");
      #1 check("irq_clr", smi_irq, 0);
      rdchk(flg, 0, "flags_clr");
    end
    // Enable gating: bit 0 off must not latch
    apb(1'b1, `ITSS_IDX_IDLE_EN, 32'hFE, '0);
    pulse(8'h01, 1'b0);
    rdchk(mir, 0, "gated");
    pulse(8'h02, 1'b0);
    apb(1'b1, flg, 32'h0, '0);
    rdchk(mir, 2, "wr_ignored");
    apb(1'b1, msk, 32'h0, '0);
    #1 check("irq_masked", smi_irq, 0);
    apb(1'b1, msk, 32'h1, '0);
    #1 check("irq_unmasked", smi_irq, 1);
    // Event lands in the clearing access phase and must survive
    apb(1'b0, flg, '0, {8'h08, 1'b0});
    check("rd_old", rd, 2);
    rdchk(mir, 8, "kept");
    rdchk(flg, 8, "kept_clr");
    pulse(8'h00, 1'b1);
    rdchk(trp, 32'h80, "trap");
    rdchk(trp, 0, "trap_clr");
    apb(1'b1, `ITSS_IDX_TRAP_EN, 32'h0, '0);
    pulse(8'h00, 1'b1);
    rdchk(trp, 0, "trap_gated");
    // Frozen clock enable must drop an enabled expiry
    @(posedge pclk);
    clk_en <= 1'b0;
    pulse(8'h04, 1'b0);
    clk_en <= 1'b1;
    rdchk(mir, 0, "frozen");
    apb(1'b0, 8'hFF, '0, '0);
    check("unmapped_err", err, 1);
    check("unmapped_rd", rd, 0);
    wrap_up();
  end
endmodule
